// ===== pkg/bsc_defines.svh
// shared constants of the branch and skip control unit
// Overview of operation
// - indirect jump loads counter from pointer pair, two cycles, flags kept.
// - indirect call pushes return address, loads pointer, three cycles, flags kept.
// - compare-skip-equal skips next word(s) on equal; 1, 2 or 3 cycles.
// - compare immediate sets Z N V C H from subtraction, one cycle.
// - skip on register bit clear; 1, 2 or 3 cycles, flags kept.
// - skip on register bit set; counter advances 2 or 3 on skip.
// - skip on I/O bit clear; 1, 2 or 3 cycles, flags kept.
// - skip on I/O bit set; 1, 2 or 3 cycles, flags kept.
// - branch on chosen status bit set to counter plus offset plus one.
// - branch on chosen status bit clear to counter plus offset plus one.
// - branch equal when zero flag is one; 1 or 2 cycles.
// - branch not equal when zero flag is zero; 1 or 2 cycles.
// - carry set and lower alias branch when carry is one.
// - carry clear and same-or-higher alias branch when carry is zero.
// - branch minus when negative flag is one; 2 taken, 1 not.
// - branch plus when negative flag is zero; 2 taken, 1 not.
// - signed greater-or-equal branches when N xor V is zero.
// - signed less-than branches when N xor V is one.
`ifndef BSC_DEFINES_SVH
`define BSC_DEFINES_SVH

`define PC_W          16
`define DATA_W        8
`define OFS_W         12
`define BR_OFS_W      7
`define CNT_W         3

`define SB_C          3'd0
`define SB_Z          3'd1
`define SB_N          3'd2
`define SB_V          3'd3
`define SB_H          3'd5
`define SB_I          3'd7
`define I_MASK        8'h80
`define CMP_MASK      8'h2F

`define CYC_ONE       3'd1
`define CYC_TWO       3'd2
`define CYC_THREE     3'd3
`define CYC_FOUR      3'd4

`define PC_STEP_ONE   16'h0001
`define PC_SKIP_SHORT 16'h0002
`define PC_SKIP_LONG  16'h0003

`define RST_PC        16'h0000
`define RST_BYTE      8'h00
`define RST_CNT       3'd0

`endif

// ===== pkg/bsc_pkg.sv
// types of the branch and skip control unit
`include "bsc_defines.svh"
package bsc_pkg;
  typedef enum logic [4:0] {
    OP_RELATIVE_JUMP        = 5'h00,
    OP_INDIRECT_JUMP        = 5'h01,
    OP_RELATIVE_CALL        = 5'h02,
    OP_INDIRECT_CALL        = 5'h03,
    OP_SUBROUTINE_RETURN    = 5'h04,
    OP_INTERRUPT_RETURN     = 5'h05,
    OP_COMPARE_SKIP_EQUAL   = 5'h06,
    OP_REGISTER_COMPARE     = 5'h07,
    OP_COMPARE_WITH_CARRY   = 5'h08,
    OP_COMPARE_IMMEDIATE    = 5'h09,
    OP_SKIP_REG_BIT_CLEAR   = 5'h0A,
    OP_SKIP_REG_BIT_SET     = 5'h0B,
    OP_SKIP_IO_BIT_CLEAR    = 5'h0C,
    OP_SKIP_IO_BIT_SET      = 5'h0D,
    OP_BRANCH_STATUS_SET    = 5'h0E,
    OP_BRANCH_STATUS_CLEAR  = 5'h0F,
    OP_BRANCH_EQUAL         = 5'h10,
    OP_BRANCH_NOT_EQUAL     = 5'h11,
    OP_BRANCH_CARRY_SET     = 5'h12,
    OP_BRANCH_CARRY_CLEAR   = 5'h13,
    OP_BRANCH_SAME_OR_HIGHER = 5'h14,
    OP_BRANCH_LOWER         = 5'h15,
    OP_BRANCH_MINUS         = 5'h16,
    OP_BRANCH_PLUS          = 5'h17,
    OP_BRANCH_SIGNED_GE     = 5'h18,
    OP_BRANCH_SIGNED_LT     = 5'h19
  } op_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_POP  = 3'b010,
    ST_WAIT = 3'b100
  } state_e;

  typedef logic [`PC_W-1:0]   addr_t;
  typedef logic [`DATA_W-1:0] byte_t;
endpackage

// ===== pkg/cond_if.sv
// carrier between sequencer and condition/flag evaluator
`timescale 1ns/100ps
`default_nettype none
interface cond_if;
  import bsc_pkg::*;
  op_e        op;
  byte_t      rd;
  byte_t      rr;
  byte_t      imm;
  byte_t      io;
  byte_t      status_register;
  logic [2:0] bit_sel;
  logic       cond_true;
  byte_t      flags_new;

  modport eval (
    input  op,
    input  rd,
    input  rr,
    input  imm,
    input  io,
    input  status_register,
    input  bit_sel,
    output cond_true,
    output flags_new
  );
  modport ctl (
    output op,
    output rd,
    output rr,
    output imm,
    output io,
    output status_register,
    output bit_sel,
    input  cond_true,
    input  flags_new
  );
endinterface
`default_nettype wire

// ===== hdl/flag_cond_eval.sv
// skip/branch condition and compare flag evaluator
`timescale 1ns/100ps
`default_nettype none
`include "bsc_defines.svh"
module flag_cond_eval (
  cond_if.eval ci
);
  import bsc_pkg::*;

  wire        use_imm   = (ci.op == OP_COMPARE_IMMEDIATE);
  wire        use_carry = (ci.op == OP_COMPARE_WITH_CARRY);
  wire byte_t sub_b     = use_imm ? ci.imm : ci.rr;
  wire        cin       = use_carry & ci.status_register[`SB_C];
  wire byte_t res       = ci.rd - sub_b - {7'h00, cin};
  wire        h_flag    = (~ci.rd[3] & sub_b[3]) | (sub_b[3] & res[3]) | (res[3] & ~ci.rd[3]);
  wire        c_flag    = (~ci.rd[7] & sub_b[7]) | (sub_b[7] & res[7]) | (res[7] & ~ci.rd[7]);
  wire        v_flag    = (ci.rd[7] & ~sub_b[7] & ~res[7]) | (~ci.rd[7] & sub_b[7] & res[7]);
  // carry variant keeps zero only if it was already set, for multi-byte compares
  wire        z_flag    = (res == `RST_BYTE) & (~use_carry | ci.status_register[`SB_Z]);
  wire byte_t upd;

  assign upd[`SB_C] = c_flag;
  assign upd[`SB_Z] = z_flag;
  assign upd[`SB_N] = res[7];
  assign upd[`SB_V] = v_flag;
  assign upd[`SB_H] = h_flag;
  assign upd[4]     = ci.status_register[4];
  assign upd[6]     = ci.status_register[6];
  assign upd[`SB_I] = ci.status_register[`SB_I];

  assign ci.flags_new = upd;

  wire nv = ci.status_register[`SB_N] ^ ci.status_register[`SB_V];

  assign ci.cond_true =
    (ci.op == OP_COMPARE_SKIP_EQUAL)    ? (ci.rd == ci.rr) :
    (ci.op == OP_SKIP_REG_BIT_CLEAR)    ? ~ci.rr[ci.bit_sel] :
    (ci.op == OP_SKIP_REG_BIT_SET)      ? ci.rr[ci.bit_sel] :
    (ci.op == OP_SKIP_IO_BIT_CLEAR)     ? ~ci.io[ci.bit_sel] :
    (ci.op == OP_SKIP_IO_BIT_SET)       ? ci.io[ci.bit_sel] :
    (ci.op == OP_BRANCH_STATUS_SET)     ? ci.status_register[ci.bit_sel] :
    (ci.op == OP_BRANCH_STATUS_CLEAR)   ? ~ci.status_register[ci.bit_sel] :
    (ci.op == OP_BRANCH_EQUAL)          ? ci.status_register[`SB_Z] :
    (ci.op == OP_BRANCH_NOT_EQUAL)      ? ~ci.status_register[`SB_Z] :
    (ci.op == OP_BRANCH_CARRY_SET)      ? ci.status_register[`SB_C] :
    (ci.op == OP_BRANCH_LOWER)          ? ci.status_register[`SB_C] :
    (ci.op == OP_BRANCH_CARRY_CLEAR)    ? ~ci.status_register[`SB_C] :
    (ci.op == OP_BRANCH_SAME_OR_HIGHER) ? ~ci.status_register[`SB_C] :
    (ci.op == OP_BRANCH_MINUS)          ? ci.status_register[`SB_N] :
    (ci.op == OP_BRANCH_PLUS)           ? ~ci.status_register[`SB_N] :
    (ci.op == OP_BRANCH_SIGNED_GE)      ? ~nv :
    (ci.op == OP_BRANCH_SIGNED_LT)      ? nv :
                                          1'b0;
endmodule
`default_nettype wire

// ===== hdl/branch_skip_control_unit.sv
// control-flow sequencer: next counter, stack traffic and cycle timing
`timescale 1ns/100ps
`default_nettype none
`include "bsc_defines.svh"
module branch_skip_control_unit #(
  parameter int PC_W = `PC_W
) (
  input  wire logic                 MCLK,
  input  wire logic                 RST,
  input  wire logic                 OP_VALID,
  input  wire bsc_pkg::op_e         OP_CODE,
  input  wire logic [`OFS_W-1:0]    OP_OFFSET,
  input  wire logic [2:0]           OP_BIT,
  input  wire bsc_pkg::byte_t       RD_VALUE,
  input  wire bsc_pkg::byte_t       RR_VALUE,
  input  wire bsc_pkg::byte_t       IMM_VALUE,
  input  wire bsc_pkg::byte_t       IO_VALUE,
  input  wire bsc_pkg::byte_t       STATUS_IN,
  input  wire logic [PC_W-1:0]      POINTER_Z,
  input  wire logic [PC_W-1:0]      PC_CURRENT,
  input  wire logic                 NEXT_TWO_WORD,
  input  wire logic [PC_W-1:0]      STACK_POP_DATA,
  output var  logic                 OP_READY,
  output var  logic                 DONE,
  output var  logic [PC_W-1:0]      PC_NEXT,
  output var  logic [`CNT_W-1:0]    CYCLE_COUNT,
  output var  bsc_pkg::byte_t       STATUS_NEXT,
  output var  logic                 STATUS_WE,
  output var  logic                 STACK_PUSH,
  output var  logic [PC_W-1:0]      STACK_PUSH_DATA,
  output var  logic                 STACK_POP
);
  import bsc_pkg::*;

  cond_if ci ();

  assign ci.op      = OP_CODE;
  assign ci.rd      = RD_VALUE;
  assign ci.rr      = RR_VALUE;
  assign ci.imm     = IMM_VALUE;
  assign ci.io      = IO_VALUE;
  assign ci.status_register    = STATUS_IN;
  assign ci.bit_sel = OP_BIT;

  flag_cond_eval u_eval (
    .ci (ci.eval)
  );

  state_e            state_ff;
  logic [`CNT_W-1:0] cnt_ff;
  logic              ready_ff;
  logic              done_ff;
  logic [PC_W-1:0]   pc_next_ff;
  logic [`CNT_W-1:0] cycles_ff;
  byte_t             status_next_ff;
  logic              status_we_ff;
  logic              we_pend_ff;
  logic              push_ff;
  logic [PC_W-1:0]   push_data_ff;
  logic              pop_ff;

  // operation classes
  wire is_relative_jump  = (OP_CODE == OP_RELATIVE_JUMP);
  wire is_indirect_jump  = (OP_CODE == OP_INDIRECT_JUMP);
  wire is_relative_call = (OP_CODE == OP_RELATIVE_CALL);
  wire is_indirect_call = (OP_CODE == OP_INDIRECT_CALL);
  wire is_ret   = (OP_CODE == OP_SUBROUTINE_RETURN);
  wire is_interrupt_return  = (OP_CODE == OP_INTERRUPT_RETURN);
  wire is_call  = is_relative_call | is_indirect_call;
  wire is_pop   = is_ret | is_interrupt_return;
  wire is_cmp   = (OP_CODE == OP_REGISTER_COMPARE) |
                  (OP_CODE == OP_COMPARE_WITH_CARRY) |
                  (OP_CODE == OP_COMPARE_IMMEDIATE);
  wire is_skip  = (OP_CODE == OP_COMPARE_SKIP_EQUAL) |
                  (OP_CODE == OP_SKIP_REG_BIT_CLEAR) |
                  (OP_CODE == OP_SKIP_REG_BIT_SET) |
                  (OP_CODE == OP_SKIP_IO_BIT_CLEAR) |
                  (OP_CODE == OP_SKIP_IO_BIT_SET);
  wire is_brch  = ~(is_relative_jump | is_indirect_jump | is_call | is_pop | is_cmp | is_skip);

  wire taken    = ci.cond_true;

  // target arithmetic, counter wraps in its own width
  wire [PC_W-1:0] pc_inc   = PC_CURRENT + PC_W'(`PC_STEP_ONE);
  wire [PC_W-1:0] br_ofs   = PC_W'(signed'(OP_OFFSET[`BR_OFS_W-1:0]));
  wire [PC_W-1:0] rj_ofs   = PC_W'(signed'(OP_OFFSET));
  wire [PC_W-1:0] br_tgt   = pc_inc + br_ofs;
  wire [PC_W-1:0] rj_tgt   = pc_inc + rj_ofs;
  // skipped instruction of two words costs one extra word and one extra cycle
  wire [PC_W-1:0] skip_tgt = PC_CURRENT +
                             (NEXT_TWO_WORD ? PC_W'(`PC_SKIP_LONG) : PC_W'(`PC_SKIP_SHORT));

  wire [PC_W-1:0] target =
    (is_relative_jump | is_relative_call)      ? rj_tgt :
    (is_indirect_jump | is_indirect_call)      ? POINTER_Z :
    (is_skip & taken)         ? skip_tgt :
    (is_brch & taken)         ? br_tgt :
                                pc_inc;

  wire [`CNT_W-1:0] op_cycles =
    (is_relative_jump | is_indirect_jump)       ? `CYC_TWO :
    is_call                   ? `CYC_THREE :
    is_pop                    ? `CYC_FOUR :
    (is_skip & taken)         ? (NEXT_TWO_WORD ? `CYC_THREE : `CYC_TWO) :
    (is_brch & taken)         ? `CYC_TWO :
                                `CYC_ONE;

  // only compares and interrupt return ever write the status register
  wire byte_t nxt_status = is_cmp  ? ci.flags_new :
                           is_interrupt_return ? (STATUS_IN | `I_MASK) :
                                     STATUS_IN;
  wire        single     = (op_cycles == `CYC_ONE);
  wire        accept     = OP_VALID & ready_ff & (state_ff == ST_IDLE);
  wire        last_wait  = (state_ff == ST_WAIT) & (cnt_ff == `CYC_ONE);

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      state_ff <= ST_IDLE;
      cnt_ff   <= `RST_CNT;
      ready_ff <= 1'b1;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          if (accept && !single) begin
            state_ff <= is_pop ? ST_POP : ST_WAIT;
            cnt_ff   <= op_cycles - `CYC_ONE;
            ready_ff <= 1'b0;
          end
        end
        ST_POP: begin
          state_ff <= ST_WAIT;
          cnt_ff   <= cnt_ff - `CYC_ONE;
        end
        ST_WAIT: begin
          cnt_ff <= cnt_ff - `CYC_ONE;
          if (last_wait) begin
            state_ff <= ST_IDLE;
            ready_ff <= 1'b1;
          end
        end
      endcase
    end
  end

  // result registers; pulses fall back to zero every cycle
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      done_ff        <= 1'b0;
      status_we_ff   <= 1'b0;
      push_ff        <= 1'b0;
      pop_ff         <= 1'b0;
    end else begin
      done_ff      <= (accept & single) | last_wait;
      status_we_ff <= (accept & single & is_cmp) | (last_wait & we_pend_ff);
      push_ff      <= accept & is_call;
      pop_ff       <= accept & is_pop;
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      pc_next_ff     <= `RST_PC;
      cycles_ff      <= `RST_CNT;
      status_next_ff <= `RST_BYTE;
      we_pend_ff     <= 1'b0;
      push_data_ff   <= `RST_PC;
    end else if (accept) begin
      pc_next_ff     <= target;
      cycles_ff      <= op_cycles;
      status_next_ff <= nxt_status;
      we_pend_ff     <= is_interrupt_return;
      push_data_ff   <= pc_inc;
    end else if (state_ff == ST_POP) begin
      // stack answers in the same cycle as the pop strobe
      pc_next_ff     <= STACK_POP_DATA;
    end
  end

  assign OP_READY        = ready_ff;
  assign DONE            = done_ff;
  assign PC_NEXT         = pc_next_ff;
  assign CYCLE_COUNT     = cycles_ff;
  assign STATUS_NEXT     = status_next_ff;
  assign STATUS_WE       = status_we_ff;
  assign STACK_PUSH      = push_ff;
  assign STACK_PUSH_DATA = push_data_ff;
  assign STACK_POP       = pop_ff;
endmodule
`default_nettype wire

// ===== testbench/bsc_assertions.sv
// concurrent checks on the ports of the branch and skip control unit
`timescale 1ns/100ps
`default_nettype none
module bsc_checker
  import bsc_pkg::*;
#(
  parameter int PC_W = 16
) (
  input wire logic            MCLK,
  input wire logic            RST,
  input wire logic            OP_VALID,
  input wire bsc_pkg::op_e    OP_CODE,
  input wire logic [11:0]     OP_OFFSET,
  input wire bsc_pkg::byte_t  STATUS_IN,
  input wire logic [PC_W-1:0] POINTER_Z,
  input wire logic [PC_W-1:0] PC_CURRENT,
  input wire logic            OP_READY,
  input wire logic            DONE,
  input wire logic [PC_W-1:0] PC_NEXT,
  input wire logic [2:0]      CYCLE_COUNT,
  input wire logic            STATUS_WE,
  input wire logic            STACK_PUSH,
  input wire logic [PC_W-1:0] STACK_PUSH_DATA,
  input wire logic            STACK_POP
);
  wire logic            acc    = OP_VALID && OP_READY;
  wire logic            is_cmp = OP_CODE inside {OP_REGISTER_COMPARE, OP_COMPARE_WITH_CARRY,
                                                 OP_COMPARE_IMMEDIATE};
  wire logic [PC_W-1:0] br_tgt = PC_CURRENT + 1'b1 + {{(PC_W-7){OP_OFFSET[6]}}, OP_OFFSET[6:0]};
  logic                 wr_ok_ff;
  // remembers whether the op in flight may write flags at all
  always_ff @(posedge MCLK or posedge RST)
    if (RST) wr_ok_ff <= 1'b0;
    else if (acc) wr_ok_ff <= is_cmp || OP_CODE == OP_INTERRUPT_RETURN;
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);

  a_compare_one_cycle: assert property (
    acc && is_cmp |=> DONE && STATUS_WE && CYCLE_COUNT == 3'd1) else $error("compare too slow");
  a_flag_write_only: assert property (
    STATUS_WE |-> wr_ok_ff && DONE) else $error("flags written by a non-compare op");
  a_ijump_target: assert property (
    acc && OP_CODE == OP_INDIRECT_JUMP |=> !OP_READY ##1 DONE && PC_NEXT == $past(POINTER_Z, 2))
    else $error("indirect jump target or timing wrong");
  a_indirect_call_push: assert property (
    acc && OP_CODE == OP_INDIRECT_CALL |=>
    STACK_PUSH && STACK_PUSH_DATA == $past(PC_CURRENT) + 1'b1
    ##2 DONE && PC_NEXT == $past(POINTER_Z, 3)) else $error("indirect call push or target wrong");
  a_return_pop: assert property (
    acc && OP_CODE inside {OP_SUBROUTINE_RETURN, OP_INTERRUPT_RETURN} |=> STACK_POP
    ##1 !STACK_POP && !OP_READY ##2 DONE && CYCLE_COUNT == 3'd4) else $error("return timing wrong");
  a_branch_taken: assert property (
    acc && OP_CODE == OP_BRANCH_EQUAL && STATUS_IN[1] |=>
    !DONE ##1 DONE && PC_NEXT == $past(br_tgt, 2))
    else $error("taken branch target wrong");
  a_branch_fall: assert property (
    acc && OP_CODE == OP_BRANCH_NOT_EQUAL && STATUS_IN[1] |=>
    DONE && PC_NEXT == $past(PC_CURRENT) + 1'b1)
    else $error("untaken branch wrong");
  a_signed_fall: assert property (
    acc && OP_CODE == OP_BRANCH_SIGNED_GE && (STATUS_IN[2] ^ STATUS_IN[3]) |=>
    DONE && CYCLE_COUNT == 3'd1)
    else $error("signed branch taken wrongly");
endmodule

bind branch_skip_control_unit bsc_checker #(.PC_W(PC_W)) u_chk (.MCLK(MCLK), .RST(RST),
  .OP_VALID(OP_VALID), .OP_CODE(OP_CODE), .OP_OFFSET(OP_OFFSET), .STATUS_IN(STATUS_IN),
  .POINTER_Z(POINTER_Z), .PC_CURRENT(PC_CURRENT), .OP_READY(OP_READY), .DONE(DONE),
  .PC_NEXT(PC_NEXT), .CYCLE_COUNT(CYCLE_COUNT), .STATUS_WE(STATUS_WE), .STACK_PUSH(STACK_PUSH),
  .STACK_PUSH_DATA(STACK_PUSH_DATA), .STACK_POP(STACK_POP));
`default_nettype wire

// ===== testbench/stack_model.sv
// return-address stack standing at the far side of the control unit
`timescale 1ns/100ps
`default_nettype none
module stack_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        push,
  input  wire logic [15:0] push_data,
  input  wire logic        pop,
  output logic      [15:0] pop_data
);
  logic      [15:0] mem_ff [8];
  logic      [2:0]  sp_ff;
  logic             hold_ff;
  wire logic [2:0]  top = sp_ff - 3'd1;
  // outside the read window the bus shows the inverse, so a late sample cannot match by luck
  assign pop_data = (pop || hold_ff) ? mem_ff[top] : ~mem_ff[top];
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sp_ff   <= 3'h0;
      hold_ff <= 1'b0;
    end else begin
      hold_ff <= pop;
      if (push) begin
        mem_ff[sp_ff] <= push_data;
        sp_ff         <= sp_ff + 3'd1;
      end else if (hold_ff) sp_ff <= top;
    end
  end
endmodule
`default_nettype wire

// ===== testbench/branch_skip_control_unit_tb_top.sv
// self-checking bench for the branch and skip control unit
`timescale 1ns/100ps
`default_nettype none
module branch_skip_control_unit_tb_top;
  import bsc_pkg::*;
  typedef struct {op_e op; logic [2:0] bt; byte_t s, a, b; logic tw; addr_t pc;
                  logic [2:0] cyc; byte_t st;} row_s;
  logic MCLK, RST, OP_VALID, NEXT_TWO_WORD, OP_READY, DONE, STATUS_WE, STACK_PUSH, STACK_POP;
  op_e OP_CODE;
  logic [11:0] OP_OFFSET;
  logic [2:0] OP_BIT, CYCLE_COUNT;
  byte_t RD_VALUE, RR_VALUE, IMM_VALUE, IO_VALUE, STATUS_IN, STATUS_NEXT;
  addr_t POINTER_Z, PC_CURRENT, STACK_POP_DATA, PC_NEXT, STACK_PUSH_DATA;
  int error_cnt = 0;
  int n_checks = 0;
  // offset 0x07E: +126 for jumps, -2 for branches, so both extensions are exercised
  row_s rows [29] = '{
    '{OP_RELATIVE_JUMP, 3'h0, 8'h00, 8'h00, 8'h00, 1'b0, 16'h017F, 3'h2, 8'h00},
    '{OP_INDIRECT_JUMP, 3'h0, 8'h00, 8'h00, 8'h00, 1'b0, 16'h1234, 3'h2, 8'h00},
    '{OP_RELATIVE_CALL, 3'h0, 8'h00, 8'h00, 8'h00, 1'b0, 16'h017F, 3'h3, 8'h00},
    '{OP_SUBROUTINE_RETURN, 3'h0, 8'h00, 8'h00, 8'h00, 1'b0, 16'h0101, 3'h4, 8'h00},
    '{OP_INDIRECT_CALL, 3'h0, 8'h00, 8'h00, 8'h00, 1'b0, 16'h1234, 3'h3, 8'h00},
    '{OP_INTERRUPT_RETURN, 3'h0, 8'h00, 8'h00, 8'h00, 1'b0, 16'h0101, 3'h4, 8'h80},
    '{OP_COMPARE_SKIP_EQUAL, 3'h0, 8'h00, 8'h05, 8'h05, 1'b1, 16'h0103, 3'h3, 8'h00},
    '{OP_COMPARE_SKIP_EQUAL, 3'h0, 8'h00, 8'h05, 8'h06, 1'b0, 16'h0101, 3'h1, 8'h00},
    '{OP_SKIP_REG_BIT_CLEAR, 3'h3, 8'h00, 8'h00, 8'h08, 1'b0, 16'h0101, 3'h1, 8'h00},
    '{OP_SKIP_REG_BIT_CLEAR, 3'h3, 8'h00, 8'h00, 8'h00, 1'b0, 16'h0102, 3'h2, 8'h00},
    '{OP_SKIP_REG_BIT_SET, 3'h3, 8'h00, 8'h00, 8'h08, 1'b1, 16'h0103, 3'h3, 8'h00},
    '{OP_SKIP_IO_BIT_CLEAR, 3'h0, 8'h00, 8'h00, 8'h00, 1'b0, 16'h0102, 3'h2, 8'h00},
    '{OP_SKIP_IO_BIT_SET, 3'h7, 8'h00, 8'h80, 8'h00, 1'b0, 16'h0102, 3'h2, 8'h00},
    '{OP_BRANCH_STATUS_SET, 3'h5, 8'h20, 8'h00, 8'h00, 1'b0, 16'h00FF, 3'h2, 8'h00},
    '{OP_BRANCH_STATUS_CLEAR, 3'h5, 8'h20, 8'h00, 8'h00, 1'b0, 16'h0101, 3'h1, 8'h00},
    '{OP_BRANCH_EQUAL, 3'h0, 8'h02, 8'h00, 8'h00, 1'b0, 16'h00FF, 3'h2, 8'h00},
    '{OP_BRANCH_NOT_EQUAL, 3'h0, 8'h02, 8'h00, 8'h00, 1'b0, 16'h0101, 3'h1, 8'h00},
    '{OP_BRANCH_CARRY_SET, 3'h0, 8'h01, 8'h00, 8'h00, 1'b0, 16'h00FF, 3'h2, 8'h00},
    '{OP_BRANCH_LOWER, 3'h0, 8'h00, 8'h00, 8'h00, 1'b0, 16'h0101, 3'h1, 8'h00},
    '{OP_BRANCH_CARRY_CLEAR, 3'h0, 8'h00, 8'h00, 8'h00, 1'b0, 16'h00FF, 3'h2, 8'h00},
    '{OP_BRANCH_SAME_OR_HIGHER, 3'h0, 8'h01, 8'h00, 8'h00, 1'b0, 16'h0101, 3'h1, 8'h00},
    '{OP_BRANCH_MINUS, 3'h0, 8'h04, 8'h00, 8'h00, 1'b0, 16'h00FF, 3'h2, 8'h00},
    '{OP_BRANCH_PLUS, 3'h0, 8'h04, 8'h00, 8'h00, 1'b0, 16'h0101, 3'h1, 8'h00},
    '{OP_BRANCH_SIGNED_GE, 3'h0, 8'h0C, 8'h00, 8'h00, 1'b0, 16'h00FF, 3'h2, 8'h00},
    '{OP_BRANCH_SIGNED_GE, 3'h0, 8'h04, 8'h00, 8'h00, 1'b0, 16'h0101, 3'h1, 8'h00},
    '{OP_BRANCH_SIGNED_LT, 3'h0, 8'h04, 8'h00, 8'h00, 1'b0, 16'h00FF, 3'h2, 8'h00},
    '{OP_REGISTER_COMPARE, 3'h0, 8'h00, 8'h05, 8'h05, 1'b0, 16'h0101, 3'h1, 8'h02},
    '{OP_COMPARE_IMMEDIATE, 3'h0, 8'h10, 8'h00, 8'h01, 1'b0, 16'h0101, 3'h1, 8'h35},
    '{OP_COMPARE_WITH_CARRY, 3'h0, 8'h03, 8'h05, 8'h04, 1'b0, 16'h0101, 3'h1, 8'h02}};

  branch_skip_control_unit u_dut (.MCLK(MCLK), .RST(RST), .OP_VALID(OP_VALID), .OP_CODE(OP_CODE),
    .OP_OFFSET(OP_OFFSET), .OP_BIT(OP_BIT), .RD_VALUE(RD_VALUE), .RR_VALUE(RR_VALUE),
    .IMM_VALUE(IMM_VALUE), .IO_VALUE(IO_VALUE), .STATUS_IN(STATUS_IN), .POINTER_Z(POINTER_Z),
    .PC_CURRENT(PC_CURRENT), .NEXT_TWO_WORD(NEXT_TWO_WORD), .STACK_POP_DATA(STACK_POP_DATA),
    .OP_READY(OP_READY), .DONE(DONE), .PC_NEXT(PC_NEXT), .CYCLE_COUNT(CYCLE_COUNT),
    .STATUS_NEXT(STATUS_NEXT), .STATUS_WE(STATUS_WE), .STACK_PUSH(STACK_PUSH),
    .STACK_PUSH_DATA(STACK_PUSH_DATA), .STACK_POP(STACK_POP));
  stack_model u_stack (.clk(MCLK), .rst(RST), .push(STACK_PUSH), .push_data(STACK_PUSH_DATA),
    .pop(STACK_POP), .pop_data(STACK_POP_DATA));

  initial begin
    MCLK = 1'b0;
    forever #2.5 MCLK = ~MCLK;
  end

  task results;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // request stays up after done so one-cycle ops follow each other on every edge
  task run(input row_s r);
    int t;
    int lat;
    OP_CODE = r.op;
    {OP_BIT, STATUS_IN, RD_VALUE, IO_VALUE} = {r.bt, r.s, r.a, r.a};
    {RR_VALUE, IMM_VALUE, NEXT_TWO_WORD, OP_VALID} = {r.b, r.b, r.tw, 1'b1};
    t = 0;
    lat = 0;
    while (OP_READY !== 1'b1 && t < 10) begin
      @(posedge MCLK);
      #1 t++;
    end
    @(posedge MCLK);
    #1;
    while (DONE !== 1'b1 && lat < 10) begin
      @(posedge MCLK);
      #1 lat++;
    end
    if (t >= 10 || lat >= 10) begin
      error_cnt++;
      results();
    end else begin
      chk("latency", 16'(lat), 16'(r.cyc) - 16'h0001);
      chk("cycle_count", 16'(CYCLE_COUNT), 16'(r.cyc));
      chk("pc_next", PC_NEXT, r.pc);
      chk("status_we", 16'(STATUS_WE), 16'(r.st != 8'h00));
      if (r.st != 8'h00) chk("status_next", 16'(STATUS_NEXT), 16'(r.st));
    end
  endtask

  initial begin
    {RST, OP_VALID, NEXT_TWO_WORD, OP_BIT} = {1'b1, 1'b0, 1'b0, 3'h0};
    OP_CODE = OP_RELATIVE_JUMP;
    {RD_VALUE, RR_VALUE, IMM_VALUE, IO_VALUE, STATUS_IN} = 40'h00_0000_0000;
    {OP_OFFSET, POINTER_Z, PC_CURRENT} = {12'h07E, 16'h1234, 16'h0100};
    repeat (8) @(posedge MCLK);
    #1 RST = 1'b0;
    foreach (rows[i]) run(rows[i]);
    $display("table of operations done");
    // a request while busy is ignored: the jump still finishes alone
    OP_CODE = OP_INDIRECT_JUMP;
    @(posedge MCLK);
    #1 OP_CODE = OP_REGISTER_COMPARE;
    @(posedge MCLK);
    #1 chk("busy_pc", PC_NEXT, 16'h1234);
    chk("busy_we", {15'h0000, STATUS_WE}, 16'h0000);
    OP_CODE = OP_INDIRECT_CALL;
    $display("refused request test done");
    @(posedge MCLK);
    #1 {OP_VALID, RST} = 2'b01;
    #1 chk("rst_ready", {15'h0000, OP_READY}, 16'h0001);
    chk("rst_out", {DONE, STATUS_WE, STACK_PUSH, STACK_POP, 12'h000}, 16'h0000);
    chk("rst_pc", PC_NEXT, 16'h0000);
    chk("rst_cycles", {13'h0000, CYCLE_COUNT}, 16'h0000);
    @(posedge MCLK);
    #1 RST = 1'b0;
    // stack must start empty again: call then return at the first edges after release
    run(rows[2]);
    run(rows[3]);
    $display("reset in mid-call test done");
    results();
  end
endmodule
`default_nettype wire
